// file: hw/ssef_top.sv
// Strap status bits and sticky error flags behind a classic Wishbone slave
//
// Contract
// - Bit 3 shows graphics strap, 1 selects port
// - Video mode disables device 1, pointer zero
// - Bit 2 shows queue depth strap
// - Sixteen-bit error flags at C8h, reset zero
// - Enabled flag rising sends hub error message
// - Flags set regardless of reporting enables
// - Write one clears, zero keeps, flags sticky
// - Bit 9 flags lock outside main memory
// - Bit 8 flags software-triggered management interrupt
// - Bit 6 flags target abort on own cycle
// - Bit 5 flags unimplemented received special cycle
// - Bit 4 flags access outside graphics aperture
// - Bit 3 flags outside access legacy or high
// - Bit 2 flags invalid translation table entry
// - Per-flag enable bit gates error message
module ssef_top
  import ssef_pkg::*;
#(
  parameter logic [7:0] CAP_NEXT_PTR = 8'h40
)
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output wire logic [31:0]       wb_dat_o,
  output wire logic              wb_ack_o,
  input  wire logic              graphics_port_strap,
  input  wire logic              address_line_seven_strap,
  output wire logic              graphics_port_function,
  output wire logic [3:0]        bus_queue_depth,
  output wire logic [3:0]        bus_queue_depth_on_bus,
  input  wire logic              dev1_cfg_req,
  output wire logic              dev1_cfg_claim,
  output wire logic              dev1_cfg_to_hub,
  input  wire logic              lock_cycle,
  input  wire logic [31:0]       lock_addr,
  input  wire logic [31:0]       top_of_memory,
  input  wire logic              sw_smi_trigger,
  input  wire logic              hub_target_abort,
  input  wire logic              hub_special_cycle,
  input  wire logic              hub_special_known,
  input  wire logic              gp_access,
  input  wire logic [31:0]       gp_addr,
  input  wire logic [31:0]       aperture_base,
  input  wire logic [31:0]       aperture_limit,
  input  wire logic              gp_xlat_done,
  input  wire logic              gp_xlat_invalid,
  output wire logic              serr_msg
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    logic [FLAG_W-1:0] err_en;
    logic [15:0]       gcmd;
    logic              strap_taken;
    logic              gfx_mode;
    logic              qdepth_max;
    logic [3:0]        qd_dev;
    logic [3:0]        qd_bus;
    logic              dev1_claim;
    logic              dev1_to_hub;
  } ssef_top_state_t;

  ssef_top_state_t   state_reg;
  ssef_top_state_t   state_next;

  ssef_err_if #(.W(FLAG_W)) err_bus ();

  logic              bus_req;
  logic              wr_commit;
  logic [FLAG_W-1:0] lane_mask;
  logic [FLAG_W-1:0] wdata16;
  logic [31:0]       read_word;
  logic [FLAG_W-1:0] event_set;
  logic              gp_outside;
  logic              gp_legacy;
  logic              gp_above_top;
  logic              lock_nonmem;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Answer lands one cycle after the request is seen; the write is
  // committed on the same edge at which the master samples ack, so a
  // clear never acts twice and never before the master sees it.
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign wr_commit = bus_req & wb_we_i & state_reg.ack;
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata16   = wb_dat_i[FLAG_W-1:0] & lane_mask;

  always_comb begin
    read_word = 32'h00000000;
    case (wb_adr_i)
      ADDR_ERROR_FLAGS: begin
        read_word[FLAG_W-1:0] = err_bus.flags & FLAG_IMPL_MASK;
      end
      ADDR_ERROR_ENABLES: begin
        read_word[FLAG_W-1:0] = state_reg.err_en;
      end
      ADDR_GLOBAL_CMD: begin
        read_word[15:0] = state_reg.gcmd;
      end
      ADDR_STRAPS: begin
        read_word[STRAP_GFX_BIT]    = state_reg.gfx_mode;
        read_word[STRAP_QDEPTH_BIT] = state_reg.qdepth_max;
      end
      ADDR_CAP_POINTER: begin
        // Without the graphics port the capability chain must end here
        read_word[7:0] = state_reg.gfx_mode ? CAP_NEXT_PTR : 8'h00;
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Error conditions
  // ----------------------------------------------------------------
  // Aperture checks only mean something for a live port access;
  // the translation result is taken whenever gp_xlat_done is high, with no aperture check.
  assign gp_outside   = (gp_addr < aperture_base) | (gp_addr > aperture_limit);
  assign gp_legacy    = (gp_addr >= LEGACY_LOW_ADDR) & (gp_addr < LEGACY_HIGH_ADDR);
  assign gp_above_top = gp_addr >= top_of_memory;
  assign lock_nonmem  = lock_addr >= top_of_memory;

  always_comb begin
    event_set                     = '0;
    event_set[NONMEMORY_LOCK_BIT] = lock_cycle & lock_nonmem;
    event_set[SW_SMI_BIT]         = sw_smi_trigger;
    event_set[TARGET_ABORT_BIT]   = hub_target_abort;
    event_set[UNKNOWN_SC_BIT]     = hub_special_cycle & ~hub_special_known;
    event_set[OUTSIDE_AP_BIT]     = gp_access & gp_outside;
    event_set[INVALID_PORT_BIT]   = gp_access & gp_outside & (gp_legacy | gp_above_top);
    event_set[BAD_XLAT_BIT]       = gp_xlat_done & gp_xlat_invalid;
  end

  // ----------------------------------------------------------------
  // Connections to flag bank and message generator
  // ----------------------------------------------------------------
  // Flags take their events with no dependence on any enable
  assign err_bus.set     = event_set;
  assign err_bus.clr     = (wr_commit && wb_adr_i == ADDR_ERROR_FLAGS) ? wdata16 : '0;
  assign err_bus.enables = state_reg.err_en;
  assign err_bus.glob_en = state_reg.gcmd[GCMD_SERR_EN_BIT];

  ssef_flag_bank u_flag_bank (
    .clock (clock),
    .rst_n (rst_n),
    .eb    (err_bus.bank)
  );

  ssef_msg_gen u_msg_gen (
    .clock    (clock),
    .rst_n    (rst_n),
    .eg       (err_bus.gen),
    .serr_msg (serr_msg)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Bus answer: ack for exactly one cycle per request
    state_next.ack   = bus_req & ~state_reg.ack;
    state_next.rdata = (bus_req & ~state_reg.ack & ~wb_we_i) ? read_word : 32'h00000000;

    // Register writes, honouring byte lanes
    if (wr_commit) begin
      case (wb_adr_i)
        ADDR_ERROR_ENABLES: begin
          state_next.err_en = (state_reg.err_en & ~lane_mask) | (wdata16 & FLAG_IMPL_MASK);
        end
        ADDR_GLOBAL_CMD: begin
          state_next.gcmd = (state_reg.gcmd & ~lane_mask) | wdata16;
        end
        default: begin
          state_next.gcmd = state_reg.gcmd;
        end
      endcase
    end

    // Straps are caught once, in the first cycle after reset release;
    // later pin changes are ignored, as for any power-up strap.
    if (!state_reg.strap_taken) begin
      state_next.strap_taken = 1'b1;
      state_next.gfx_mode    = graphics_port_strap;
      state_next.qdepth_max  = address_line_seven_strap;
      state_next.qd_dev      = address_line_seven_strap ? QDEPTH_DEV_MAX : QDEPTH_MIN;
      state_next.qd_bus      = address_line_seven_strap ? QDEPTH_BUS_MAX : QDEPTH_MIN;
    end

    // Device 1 exists only in graphics port mode; otherwise its
    // configuration cycles fall through to the hub.
    state_next.dev1_claim  = dev1_cfg_req & state_reg.gfx_mode;
    state_next.dev1_to_hub = dev1_cfg_req & ~state_reg.gfx_mode;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg.ack         <= 1'b0;
      state_reg.rdata       <= 32'h00000000;
      state_reg.err_en      <= ERROR_EN_RESET;
      state_reg.gcmd        <= GLOBAL_CMD_RESET;
      state_reg.strap_taken <= 1'b0;
      state_reg.gfx_mode    <= 1'b0;
      state_reg.qdepth_max  <= 1'b0;
      state_reg.qd_dev      <= QDEPTH_MIN;
      state_reg.qd_bus      <= QDEPTH_MIN;
      state_reg.dev1_claim  <= 1'b0;
      state_reg.dev1_to_hub <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o               = state_reg.ack;
  assign wb_dat_o               = state_reg.rdata;
  assign graphics_port_function = state_reg.gfx_mode;
  assign bus_queue_depth        = state_reg.qd_dev;
  assign bus_queue_depth_on_bus = state_reg.qd_bus;
  assign dev1_cfg_claim         = state_reg.dev1_claim;
  assign dev1_cfg_to_hub        = state_reg.dev1_to_hub;

endmodule : ssef_top

// file: include/ssef_pkg.sv
// Package: register map, field positions, reset values and limits for the strap and error flag bank
package ssef_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned     ADDR_W             = 8;
  localparam logic [7:0]      ADDR_ERROR_FLAGS   = 8'hc8;
  localparam logic [7:0]      ADDR_ERROR_ENABLES = 8'hca;
  localparam logic [7:0]      ADDR_GLOBAL_CMD    = 8'hd0;
  localparam logic [7:0]      ADDR_STRAPS        = 8'hd4;
  localparam logic [7:0]      ADDR_CAP_POINTER   = 8'hd8;

  // ----------------------------------------------------------------
  // Widths, reset values and masks
  // ----------------------------------------------------------------
  localparam int unsigned     FLAG_W             = 16;
  localparam logic [15:0]     ERROR_FLAGS_RESET  = 16'h0000;
  localparam logic [15:0]     ERROR_EN_RESET     = 16'h0000;
  localparam logic [15:0]     GLOBAL_CMD_RESET   = 16'h0000;
  localparam logic [15:0]     FLAG_IMPL_MASK     = 16'h037c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned     NONMEMORY_LOCK_BIT = 9;
  localparam int unsigned     SW_SMI_BIT         = 8;
  localparam int unsigned     TARGET_ABORT_BIT   = 6;
  localparam int unsigned     UNKNOWN_SC_BIT     = 5;
  localparam int unsigned     OUTSIDE_AP_BIT     = 4;
  localparam int unsigned     INVALID_PORT_BIT   = 3;
  localparam int unsigned     BAD_XLAT_BIT       = 2;
  localparam int unsigned     STRAP_GFX_BIT      = 3;
  localparam int unsigned     STRAP_QDEPTH_BIT   = 2;
  localparam int unsigned     GCMD_SERR_EN_BIT   = 8;

  // ----------------------------------------------------------------
  // Address windows and queue depths
  // ----------------------------------------------------------------
  localparam logic [31:0]     LEGACY_LOW_ADDR    = 32'h000a0000;
  localparam logic [31:0]     LEGACY_HIGH_ADDR   = 32'h00100000;
  localparam logic [3:0]      QDEPTH_MIN         = 4'h1;
  localparam logic [3:0]      QDEPTH_DEV_MAX     = 4'h8;
  localparam logic [3:0]      QDEPTH_BUS_MAX     = 4'hc;

endpackage : ssef_pkg

// file: include/ssef_err_if.sv
// Interface: error flag set, clear, state and enable signals between the bank's modules
interface ssef_err_if #(parameter int unsigned W = 16);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;
  logic [W-1:0] rise;
  logic [W-1:0] enables;
  logic         glob_en;

  modport bank (input set, input clr, output flags, output rise);
  modport gen  (input rise, input enables, input glob_en);
  modport ctrl (output set, output clr, output enables, output glob_en, input flags);
endinterface : ssef_err_if

// file: hw/ssef_flag_bank.sv
// Sticky error flags with write-one-to-clear and rising-edge detection
module ssef_flag_bank
  import ssef_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  ssef_err_if.bank eb
);

  typedef struct packed {
    logic [FLAG_W-1:0] flags;
  } ssef_bank_state_t;

  ssef_bank_state_t  state_reg;
  ssef_bank_state_t  state_next;
  logic [FLAG_W-1:0] bit_next;

  // ----------------------------------------------------------------
  // Per-bit next value
  // ----------------------------------------------------------------
  // A set in the cycle of a clear wins so no event is lost
  for (genvar i = 0; i < FLAG_W; i++) begin : g_bit
    if (FLAG_IMPL_MASK[i]) begin : g_impl
      assign bit_next[i] = eb.set[i] | (state_reg.flags[i] & ~eb.clr[i]);
    end else begin : g_rsvd
      assign bit_next[i] = 1'b0;
    end
  end

  always_comb begin
    state_next       = state_reg;
    state_next.flags = bit_next;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg.flags <= ERROR_FLAGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign eb.flags = state_reg.flags;
  assign eb.rise  = eb.set & ~state_reg.flags & FLAG_IMPL_MASK;

endmodule : ssef_flag_bank

// file: hw/ssef_msg_gen.sv
// Hub system error message generator gated by per-flag and global enables
module ssef_msg_gen
  import ssef_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  ssef_err_if.gen   eg,
  output wire logic serr_msg
);

  typedef struct packed {
    logic msg;
  } ssef_msg_state_t;

  ssef_msg_state_t state_reg;
  ssef_msg_state_t state_next;

  always_comb begin
    state_next     = state_reg;
    state_next.msg = eg.glob_en & (|(eg.rise & eg.enables));
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg.msg <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign serr_msg = state_reg.msg;

endmodule : ssef_msg_gen

// file: tb/ssef_monitor.sv
// Checker: port-level assertions for the strap and error flag bank
module ssef_monitor
  import ssef_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        graphics_port_strap,
  input wire logic        address_line_seven_strap,
  input wire logic        graphics_port_function,
  input wire logic [3:0]  bus_queue_depth,
  input wire logic [3:0]  bus_queue_depth_on_bus,
  input wire logic        dev1_cfg_req,
  input wire logic        dev1_cfg_claim,
  input wire logic        dev1_cfg_to_hub,
  input wire logic        lock_cycle,
  input wire logic        sw_smi_trigger,
  input wire logic        hub_target_abort,
  input wire logic        hub_special_cycle,
  input wire logic        gp_access,
  input wire logic        gp_xlat_done,
  input wire logic        serr_msg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ev_any;
  assign ev_any = lock_cycle | sw_smi_trigger | hub_target_abort | hub_special_cycle | gp_access | gp_xlat_done;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_req ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack; s_req |=> s_ack; endproperty
  property p_idle_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_rsv; s_rd(ADDR_ERROR_FLAGS) |=> (wb_dat_o & ~{16'h0, FLAG_IMPL_MASK}) == 32'h0; endproperty
  property p_strap_rd;
    s_rd(ADDR_STRAPS) |=> wb_dat_o[3] == graphics_port_function && wb_dat_o[2] == (bus_queue_depth == QDEPTH_DEV_MAX);
  endproperty
  property p_cap; s_rd(ADDR_CAP_POINTER) ##0 !graphics_port_function |=> wb_dat_o == 32'h0; endproperty
  property p_gfx; $rose(rst_n) |=> graphics_port_function == $past(graphics_port_strap); endproperty
  property p_depth;
    $rose(rst_n) |=> bus_queue_depth == ($past(address_line_seven_strap) ? QDEPTH_DEV_MAX : QDEPTH_MIN)
      && bus_queue_depth_on_bus == ($past(address_line_seven_strap) ? QDEPTH_BUS_MAX : QDEPTH_MIN);
  endproperty
  property p_dev1;
    dev1_cfg_req |=> dev1_cfg_claim == graphics_port_function && dev1_cfg_to_hub == !graphics_port_function;
  endproperty
  // A message can only follow an event, never arise on its own
  property p_serr; serr_msg |-> $past(ev_any); endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_idle_dat: assert property (p_idle_dat) else $error("read data outside ack");
  a_rsv: assert property (p_rsv) else $error("reserved flag bit reads one");
  a_strap_rd: assert property (p_strap_rd) else $error("strap read mismatch");
  a_cap: assert property (p_cap) else $error("pointer not zero in video mode");
  a_gfx: assert property (p_gfx) else $error("graphics strap not captured");
  a_depth: assert property (p_depth) else $error("queue depth wrong");
  a_dev1: assert property (p_dev1) else $error("device 1 routing wrong");
  a_serr: assert property (p_serr) else $error("message without event");
endmodule : ssef_monitor

// file: tb/ssef_hub_model.sv
// Partner: hub side that counts system error messages
module ssef_hub_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic serr_msg,
  output int        msg_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clock) begin
    if (!rst_n) msg_cnt <= 0;
    // An unknown request is counted too, so it shows up as a wrong count
    else if (serr_msg !== 1'b0) msg_cnt <= msg_cnt + 1;
  end
endmodule : ssef_hub_model

// file: tb/tb_ssef_top.sv
// Testbench: strap and error flag bank over Wishbone
module tb_ssef_top
  import ssef_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0]  CAP_PTR = 8'h5c;
  localparam logic [15:0] EVB [8] = '{16'h0200, 16'h0100, 16'h0040, 16'h0020, 16'h0010, 16'h0018, 16'h0004, 16'h0};
  logic        clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, graphics_port_strap;
  logic        address_line_seven_strap, graphics_port_function, dev1_cfg_req, dev1_cfg_claim;
  logic        dev1_cfg_to_hub, lock_cycle, sw_smi_trigger, hub_target_abort, hub_special_cycle;
  logic        hub_special_known, gp_access, gp_xlat_done, gp_xlat_invalid, serr_msg, gs, as;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, bus_queue_depth, bus_queue_depth_on_bus;
  logic [31:0] wb_dat_i, wb_dat_o, lock_addr, top_of_memory, gp_addr, aperture_base, aperture_limit, r;
  logic [31:0] rd_q [$];
  logic [15:0] fl;
  int          error_cnt, num_checks, msg_cnt, base;
  ssef_top #(.CAP_NEXT_PTR(CAP_PTR)) dut_u (.*);
  ssef_hub_model hub_u (.clock(clock), .rst_n(rst_n), .serr_msg(serr_msg), .msg_cnt(msg_cnt));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 16'h0, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      close_out();
    end
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back({16'h0, e});
    bus(1'b0, a, 16'h0);
  endtask : rd
  task automatic do_reset(input logic g, input logic a);
    {graphics_port_strap, address_line_seven_strap, rst_n} <= {g, a, 1'b0};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : do_reset
  // Negative case mixes near-miss conditions that must set nothing
  task automatic ev(input int k);
    @(posedge clock);
    case (k)
      0: {lock_cycle, lock_addr} <= {1'b1, top_of_memory + $urandom_range(32'hfff)};
      1: sw_smi_trigger <= 1'b1;
      2: hub_target_abort <= 1'b1;
      3: {hub_special_cycle, hub_special_known} <= 2'b10;
      4: {gp_access, gp_addr} <= {1'b1, LEGACY_HIGH_ADDR + $urandom_range(32'hfff)};
      5: {gp_access, gp_addr} <= {1'b1, $urandom_range(1) ? LEGACY_LOW_ADDR : top_of_memory};
      6: {gp_xlat_done, gp_xlat_invalid} <= 2'b11;
      default: begin
        {lock_cycle, lock_addr, hub_special_cycle, gp_xlat_done} <= {1'b1, top_of_memory - 1, 2'b11};
        {gp_access, gp_addr} <= {1'b1, aperture_limit};
      end
    endcase
    @(posedge clock);
    {lock_cycle, sw_smi_trigger, hub_target_abort, hub_special_cycle} <= 4'h0;
    {gp_access, gp_xlat_done, gp_xlat_invalid, hub_special_known} <= 4'h1;
    repeat (2) @(posedge clock);
  endtask : ev
  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) chk("rd_q", 32'h1, 32'h0);
      else chk("rd_data", rd_q.pop_front(), wb_dat_o);
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, dev1_cfg_req} = '0;
    {lock_cycle, lock_addr, sw_smi_trigger, hub_target_abort, hub_special_cycle} = '0;
    {gp_access, gp_addr, gp_xlat_done, gp_xlat_invalid, error_cnt, num_checks} = '0;
    {hub_special_known, wb_sel_i, top_of_memory} = {1'b1, 4'h3, 32'h10000000};
    {aperture_base, aperture_limit} = {32'h20000000, 32'h2fffffff};
    {graphics_port_strap, address_line_seven_strap} = 2'b00;
    void'($urandom(32'he68237f4));
    r = $urandom;
    for (int p = 0; p < 2; p++) begin
      gs = r[0] ^ p[0];
      as = r[1] ^ p[0];
      do_reset(gs, as);
      rd(ADDR_ERROR_FLAGS, ERROR_FLAGS_RESET);
      rd(ADDR_STRAPS, {12'h0, gs, as, 2'b00});
      rd(ADDR_CAP_POINTER, gs ? {8'h0, CAP_PTR} : 16'h0);
      chk("depth", as ? QDEPTH_DEV_MAX : QDEPTH_MIN, bus_queue_depth);
      chk("depth_bus", as ? QDEPTH_BUS_MAX : QDEPTH_MIN, bus_queue_depth_on_bus);
      dev1_cfg_req <= 1'b1;
      @(posedge clock);
      dev1_cfg_req <= 1'b0;
      #1;
      chk("dev1", {gs, ~gs}, {dev1_cfg_claim, dev1_cfg_to_hub});
      ev(1);
    end
    rd(ADDR_ERROR_FLAGS, EVB[1]);
    rd(8'h10, 16'h0);
    bus(1'b1, ADDR_ERROR_FLAGS, 16'hffff);
    bus(1'b1, ADDR_ERROR_ENABLES, 16'hffff);
    fl = 16'h0;
    for (int k = 0; k < 8; k++) begin
      ev(k);
      fl |= EVB[k];
      rd(ADDR_ERROR_FLAGS, fl);
    end
    chk("msg_glob_off", 32'h0, msg_cnt);
    r = $urandom;
    bus(1'b1, ADDR_ERROR_FLAGS, r[15:0]);
    fl &= ~r[15:0];
    rd(ADDR_ERROR_FLAGS, fl);
    bus(1'b1, ADDR_ERROR_FLAGS, 16'h0);
    rd(ADDR_ERROR_FLAGS, fl);
    bus(1'b1, ADDR_GLOBAL_CMD, 16'h0100);
    bus(1'b1, ADDR_ERROR_ENABLES, EVB[1]);
    bus(1'b1, ADDR_ERROR_FLAGS, 16'hffff);
    ev(2);
    chk("msg_masked", 32'h0, msg_cnt);
    rd(ADDR_ERROR_FLAGS, EVB[2]);
    ev(1);
    ev(1);
    chk("msg_once", 32'h1, msg_cnt);
    bus(1'b1, ADDR_ERROR_ENABLES, 16'hffff);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, ADDR_ERROR_FLAGS, 16'hffff);
      base = msg_cnt;
      ev(k);
      chk("msg_each", base + (k < 7), msg_cnt);
    end
    close_out();
  end
endmodule : tb_ssef_top

bind ssef_top ssef_monitor mon_u (.*);
